// >>> logic/ssp_pkg.sv
// Constants, register map and state types of the synchronous serial port.
// Assumes a 25 MHz core clock and an 8-bit register bus with 16-bit addresses.
`default_nettype none

package ssp_pkg;

    // Register byte addresses.
    localparam logic [15:0] SERIAL_CONTROL_ADDR = 16'h0010;
    localparam logic [15:0] SERIAL_STATUS_ADDR = 16'h0011;
    localparam logic [15:0] SERIAL_SHIFT_DATA_ADDR = 16'h0012;

    // Control field positions.
    localparam int CTL_TX_PIN_ENABLE = 7;
    localparam int CTL_RX_PIN_ENABLE = 6;
    localparam int CTL_CLK_SRC_HI = 5;
    localparam int CTL_CLK_SRC_LO = 4;
    localparam int CTL_RATE_MSB = 3;
    localparam int CTL_RATE_LSB = 0;

    // Status field positions.
    localparam int ST_XFER_DONE_FLAG = 7;
    localparam int ST_RATE_TICK_FLAG = 6;
    localparam int ST_XFER_DONE_MASK = 5;
    localparam int ST_RATE_TICK_MASK = 4;
    localparam int ST_RATE_PRESCALER_CLEAR = 3;

    // Reset values.
    localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic MASK_RESET = 1'b1;
    localparam logic [7:0] SHIFT_DATA_RESET = 8'h00;

    // Clock source codes.
    localparam logic [1:0] CLK_SRC_INTERNAL = 2'h2;
    localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h3;

    // Half of one E cycle, the fastest transfer clock phase.
    localparam int CLK_PERIOD_NS = 40;
    localparam int E_HALF_NS = 500;
    localparam int E_HALF_CYCLES = (E_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : (E_HALF_NS / CLK_PERIOD_NS);
    localparam logic [3:0] E_HALF_LAST = 4'(E_HALF_CYCLES - 1);

    // Bits per transfer, counted from zero.
    localparam logic [3:0] LAST_BIT = 4'h7;

    // Transfer state.
    typedef enum logic [0:0] {
        SSP_IDLE,
        SSP_SHIFT
    } ssp_state_t;

    // Prescaler state.
    typedef struct packed {
        logic [3:0] div;
        logic [15:0] cnt;
        logic iclk;
        logic fall;
        logic rise;
    } ssp_presc_state_t;

    // Serial port state.
    typedef struct packed {
        logic [7:0] ctl;
        logic done;
        logic tick;
        logic done_mask;
        logic tick_mask;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        ssp_state_t state;
        logic txd;
        logic tx_oe_n;
        logic [7:0] rdata;
        logic clk_s1;
        logic clk_s2;
        logic clk_prev;
        logic rx_s1;
        logic rx_s2;
        logic clk_o;
        logic clk_oe_n;
        logic xfer_irq;
        logic tick_irq;
    } ssp_top_state_t;

endpackage

`default_nettype wire

// >>> logic/ssp_prescaler.sv
// Transfer clock generator: divides the core clock to half E cycles,
// then a binary chain whose selected tap is the internal transfer clock.
// Assumes clear and rate come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module ssp_prescaler (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Control.
    input wire logic clear,
    input wire logic [3:0] rate,
    // Transfer clock level and its edges as one-cycle pulses.
    output logic iclk,
    output logic fall,
    output logic rise
);

    localparam ssp_pkg::ssp_presc_state_t PRESC_RESET = '{div: 4'h0, cnt: 16'h0000,
        iclk: 1'b1, fall: 1'b0, rise: 1'b0};

    ssp_pkg::ssp_presc_state_t st;
    ssp_pkg::ssp_presc_state_t nx;

    // Next state: count half E cycles, then pick the tap of the selected rate.
    always_comb begin
        nx = st;
        if (clear) begin
            nx.div = 4'h0;
            nx.cnt = 16'h0000;
        end else if (st.div == ssp_pkg::E_HALF_LAST) begin
            nx.div = 4'h0;
            nx.cnt = st.cnt + 16'h0001;
        end else begin
            nx.div = st.div + 4'h1;
        end
        nx.iclk = ~nx.cnt[rate];
        nx.fall = st.iclk & ~nx.iclk;
        nx.rise = ~st.iclk & nx.iclk & ~clear; // A restart is not a clock edge.
    end

    // State register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= PRESC_RESET;
        end else begin
            st <= nx;
        end
    end

    assign iclk = st.iclk;
    assign fall = st.fall;
    assign rise = st.rise;

endmodule // ssp_prescaler

`default_nettype wire

// >>> logic/ssp_top.sv
// Synchronous serial port with a shared transfer clock that also acts as a periodic timer.
// Assumes single-cycle read and write strobes from the CPU bus and asynchronous port pins.
//
// Behaviour
// - Transmit pin enable makes the data-out pin an output carrying serial data.
// - Receive pin enable makes the data-in pin an input used for serial data.
// - Clock source 00/01 leaves pin general, 10 drives clock out, 11 takes clock in.
// - Four-bit rate picks sixteen clock periods, doubling from one E cycle upward.
// - Reset clears the whole control register.
// - Done flag sets after eight bits; cleared by reset, zero write, or data access while clock source is 10 or 11.
// - Timer flag sets on each internal clock falling edge; cleared by reset or zero write.
// - Done mask, reset to one, blocks the done interrupt request.
// - Timer mask, reset to one, blocks the timer interrupt request.
// - Writing one to status bit 3 restarts the prescaler; it reads as zero.
// - Written byte shifts out least significant bit first on falling clock edges.
// - Transmit completion sets the done flag on the eighth rising edge.
// - Data pin keeps the last shifted bit until the next transfer.
// - External clock ignores the rate; internal clock is driven at the selected rate.
// - Receive data is sampled on rising clock edges; done after eight bits.
// - Any data access with the internal source restarts the prescaler.
`timescale 1ns/1ns
`default_nettype none

module ssp_top (
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // CPU register bus.
    input wire logic [15:0] ADDR,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    // Serial data pins.
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE_N,
    input wire logic SERIAL_IN,
    // Serial clock pin, split into input, output and enable.
    input wire logic SERIAL_CLK_I,
    output logic SERIAL_CLK_O,
    output logic SERIAL_CLK_OE_N,
    // Port pin ownership towards the general I/O logic.
    output logic TX_PIN_SERIAL,
    output logic RX_PIN_SERIAL,
    output logic CLK_PIN_SERIAL,
    // Masked interrupt requests.
    output logic XFER_IRQ,
    output logic TICK_IRQ
);

    localparam ssp_pkg::ssp_top_state_t TOP_RESET = '{
        ctl: ssp_pkg::SERIAL_CONTROL_RESET,
        done: ssp_pkg::FLAG_RESET,
        tick: ssp_pkg::FLAG_RESET,
        done_mask: ssp_pkg::MASK_RESET,
        tick_mask: ssp_pkg::MASK_RESET,
        shreg: ssp_pkg::SHIFT_DATA_RESET,
        bitcnt: 4'h0,
        state: ssp_pkg::SSP_IDLE,
        txd: 1'b0,
        tx_oe_n: 1'b1,
        rdata: 8'h00,
        clk_s1: 1'b1,
        clk_s2: 1'b1,
        clk_prev: 1'b1,
        rx_s1: 1'b0,
        rx_s2: 1'b0,
        clk_o: 1'b1,
        clk_oe_n: 1'b1,
        xfer_irq: 1'b0,
        tick_irq: 1'b0
    };

    // Address match of one register.
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
        addr_hit = (addr == target);
    endfunction

    ssp_pkg::ssp_top_state_t st;
    ssp_pkg::ssp_top_state_t nx;

    logic wr_ctl;
    logic wr_stat;
    logic wr_data;
    logic rd_stat;
    logic rd_ctl;
    logic rd_data;
    logic data_access;
    logic [1:0] clk_src;
    logic src_internal;
    logic src_external;
    logic presc_clear;
    logic pre_iclk;
    logic pre_fall;
    logic pre_rise;
    logic ext_fall;
    logic ext_rise;
    logic sh_fall;
    logic sh_rise;
    logic [7:0] stat_value;

    // Register decode.
    assign wr_ctl = WR_STB & addr_hit(ADDR, ssp_pkg::SERIAL_CONTROL_ADDR);
    assign wr_stat = WR_STB & addr_hit(ADDR, ssp_pkg::SERIAL_STATUS_ADDR);
    assign wr_data = WR_STB & addr_hit(ADDR, ssp_pkg::SERIAL_SHIFT_DATA_ADDR);
    assign rd_ctl = RD_STB & addr_hit(ADDR, ssp_pkg::SERIAL_CONTROL_ADDR);
    assign rd_stat = RD_STB & addr_hit(ADDR, ssp_pkg::SERIAL_STATUS_ADDR);
    assign rd_data = RD_STB & addr_hit(ADDR, ssp_pkg::SERIAL_SHIFT_DATA_ADDR);
    assign data_access = wr_data | rd_data;

    // Clock source selection.
    assign clk_src = st.ctl[ssp_pkg::CTL_CLK_SRC_HI:ssp_pkg::CTL_CLK_SRC_LO];
    assign src_internal = (clk_src == ssp_pkg::CLK_SRC_INTERNAL);
    assign src_external = (clk_src == ssp_pkg::CLK_SRC_EXTERNAL);

    // Prescaler restart from the status command or a data access on the internal clock.
    assign presc_clear = (wr_stat & WDATA[ssp_pkg::ST_RATE_PRESCALER_CLEAR])
        | (data_access & src_internal);

    ssp_prescaler u_prescaler (
        .clk(CLK),
        .nrst(NRST),
        .clear(presc_clear),
        .rate(st.ctl[ssp_pkg::CTL_RATE_MSB:ssp_pkg::CTL_RATE_LSB]),
        .iclk(pre_iclk),
        .fall(pre_fall),
        .rise(pre_rise)
    );

    // Edges of the synchronised external clock.
    assign ext_fall = ~st.clk_s2 & st.clk_prev;
    assign ext_rise = st.clk_s2 & ~st.clk_prev;

    // Shift clock: the pin when external, the rate generator when internal, nothing otherwise.
    assign sh_fall = src_external ? ext_fall : (src_internal & pre_fall);
    assign sh_rise = src_external ? ext_rise : (src_internal & pre_rise);

    // Status read image; the prescaler command bit and bits 2 to 0 read as zero.
    assign stat_value = {st.done, st.tick, st.done_mask, st.tick_mask, 4'h0};

    // Next state of the whole port.
    always_comb begin
        nx = st;
        // Pin synchronisers.
        nx.clk_s1 = SERIAL_CLK_I;
        nx.clk_s2 = st.clk_s1;
        nx.clk_prev = st.clk_s2;
        nx.rx_s1 = SERIAL_IN;
        nx.rx_s2 = st.rx_s1;
        // Control write.
        if (wr_ctl) begin
            nx.ctl = WDATA;
        end
        // Status write: flags only clear by zero, masks take the written value.
        if (wr_stat) begin
            if (!WDATA[ssp_pkg::ST_XFER_DONE_FLAG]) begin
                nx.done = 1'b0;
            end
            if (!WDATA[ssp_pkg::ST_RATE_TICK_FLAG]) begin
                nx.tick = 1'b0;
            end
            nx.done_mask = WDATA[ssp_pkg::ST_XFER_DONE_MASK];
            nx.tick_mask = WDATA[ssp_pkg::ST_RATE_TICK_MASK];
        end
        // Data access with clock source high bit set clears the done flag.
        if (data_access && st.ctl[ssp_pkg::CTL_CLK_SRC_HI]) begin
            nx.done = 1'b0;
        end
        // Timer tick on every internal falling edge; the set wins over a clear.
        if (pre_fall) begin
            nx.tick = 1'b1;
        end
        // Shifting.
        case (st.state)
            ssp_pkg::SSP_IDLE: begin
                nx.state = ssp_pkg::SSP_IDLE;
            end
            ssp_pkg::SSP_SHIFT: begin
                if (sh_fall) begin
                    nx.txd = st.shreg[0];
                end
                if (sh_rise) begin
                    nx.shreg = {st.rx_s2 & st.ctl[ssp_pkg::CTL_RX_PIN_ENABLE], st.shreg[7:1]};
                    nx.bitcnt = st.bitcnt + 4'h1;
                    if (st.bitcnt == ssp_pkg::LAST_BIT) begin
                        nx.state = ssp_pkg::SSP_IDLE;
                        nx.done = 1'b1;
                    end
                end
            end
            default: begin
                nx.state = ssp_pkg::SSP_IDLE;
            end
        endcase
        // Any data access arms a new transfer; a write also loads the byte.
        if (data_access) begin
            nx.state = ssp_pkg::SSP_SHIFT;
            nx.bitcnt = 4'h0;
        end
        if (wr_data) begin
            nx.shreg = WDATA;
        end
        // Read data register.
        if (rd_ctl) begin
            nx.rdata = st.ctl;
        end else if (rd_stat) begin
            nx.rdata = stat_value;
        end else if (rd_data) begin
            nx.rdata = st.shreg;
        end else if (RD_STB) begin
            nx.rdata = 8'h00;
        end
        // Clock pin: driven only for the internal source, idling high between transfers.
        // A prescaler restart holds the pin high, so a restart in the low phase makes no stray pulse.
        nx.clk_oe_n = ~(nx.ctl[ssp_pkg::CTL_CLK_SRC_HI] & ~nx.ctl[ssp_pkg::CTL_CLK_SRC_LO]);
        nx.clk_o = ((nx.state == ssp_pkg::SSP_SHIFT) && !presc_clear) ? pre_iclk : 1'b1;
        // Transmit pin enable, kept in a flip-flop of its own.
        nx.tx_oe_n = ~nx.ctl[ssp_pkg::CTL_TX_PIN_ENABLE];
        // Masked requests.
        nx.xfer_irq = nx.done & ~nx.done_mask;
        nx.tick_irq = nx.tick & ~nx.tick_mask;
    end

    // State register.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st <= TOP_RESET;
        end else begin
            st <= nx;
        end
    end

    // Outputs, each taken from a state flip-flop.
    assign RDATA = st.rdata;
    assign SERIAL_OUT = st.txd;
    assign SERIAL_OUT_OE_N = st.tx_oe_n;
    assign SERIAL_CLK_O = st.clk_o;
    assign SERIAL_CLK_OE_N = st.clk_oe_n;
    assign TX_PIN_SERIAL = st.ctl[ssp_pkg::CTL_TX_PIN_ENABLE];
    assign RX_PIN_SERIAL = st.ctl[ssp_pkg::CTL_RX_PIN_ENABLE];
    assign CLK_PIN_SERIAL = st.ctl[ssp_pkg::CTL_CLK_SRC_HI];
    assign XFER_IRQ = st.xfer_irq;
    assign TICK_IRQ = st.tick_irq;

    // Checks on the port behaviour.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    // Last rising shift edge of a byte.
    sequence s_last_rise;
        (st.state == ssp_pkg::SSP_SHIFT) && (st.bitcnt == ssp_pkg::LAST_BIT) && sh_rise && !data_access;
    endsequence

    // Completion seen: idle with the done flag up.
    sequence s_byte_done;
        (st.state == ssp_pkg::SSP_IDLE) && st.done;
    endsequence

    tx_pin_drive_a: assert property (wr_ctl && WDATA[7] |=> !SERIAL_OUT_OE_N && TX_PIN_SERIAL)
        else $error("Transmit pin not driven after enable.");

    rx_pin_own_a: assert property (wr_ctl && WDATA[6] |=> RX_PIN_SERIAL)
        else $error("Receive pin not taken after enable.");

    clk_pin_dir_a: assert property (wr_ctl && (WDATA[5:4] == 2'h3) |=> ##1 SERIAL_CLK_OE_N && CLK_PIN_SERIAL)
        else $error("External clock pin is driven.");

    clk_pin_drive_a: assert property (wr_ctl && (WDATA[5:4] == 2'h2) |=> !SERIAL_CLK_OE_N && CLK_PIN_SERIAL)
        else $error("Internal clock pin is not driven.");

    done_eighth_a: assert property (s_last_rise |=> s_byte_done)
        else $error("Done flag missing after eighth rising edge.");

    done_clear_a: assert property (data_access && st.ctl[ssp_pkg::CTL_CLK_SRC_HI]
        && !((st.state == ssp_pkg::SSP_SHIFT) && (st.bitcnt == ssp_pkg::LAST_BIT) && sh_rise) |=> !st.done)
        else $error("Done flag not cleared by data access.");

    tick_on_fall_a: assert property (pre_fall |=> st.tick)
        else $error("Timer flag not set on falling edge.");

    done_irq_gate_a: assert property (XFER_IRQ == (st.done && !st.done_mask))
        else $error("Done request does not follow flag and mask.");

    tick_irq_gate_a: assert property (TICK_IRQ == (st.tick && !st.tick_mask))
        else $error("Timer request does not follow flag and mask.");

    presc_restart_a: assert property (presc_clear |=> pre_iclk && !pre_rise)
        else $error("Prescaler not restarted.");

    tx_lsb_first_a: assert property ((st.state == ssp_pkg::SSP_SHIFT) && sh_fall |=> SERIAL_OUT == $past(st.shreg[0]))
        else $error("Transmit bit out of order.");

    tx_hold_a: assert property ((st.state == ssp_pkg::SSP_IDLE) && !data_access |=> $stable(SERIAL_OUT))
        else $error("Data pin changed between transfers.");

    rx_sample_a: assert property ((st.state == ssp_pkg::SSP_SHIFT) && sh_rise && !data_access
        |=> st.shreg[7] == $past(st.rx_s2 && st.ctl[6]))
        else $error("Receive bit not sampled on rising edge.");

endmodule // ssp_top

`default_nettype wire

// >>> sim/ssp_peer.sv
// Far-side serial peripheral model: shifts a byte back and captures the port's byte.
// Assumes the bench resolves the clock pin and feeds its level in as line.
`timescale 1ns/1ns
`default_nettype none

module ssp_peer (
    // Resolved clock pin and the port's data output.
    input wire logic line,
    input wire logic sdo,
    // Data towards the port and the clock the peer drives.
    output logic sdi,
    output logic ext_clk
);
    logic [7:0] rx_byte = 8'h00;
    logic [7:0] cap = 8'h00;
    int n = 8;
    bit fell = 1'b0;
    time t_fall = 0;
    time t_rise = 0;
    time period = 0;

    // The clock pin idles high and the data line starts at one.
    initial begin
        sdi = 1'b1;
        ext_clk = 1'b1;
    end

    // Starts a frame with a fresh byte to send back.
    task automatic arm(input logic [7:0] b);
        rx_byte = b;
        n = 0;
        fell = 1'b0;
    endtask

    // Drives eight clock pulses and then stands still, high.
    task automatic ext_frame(input int half);
        repeat (8) begin
            #(half) ext_clk = 1'b0;
            #(half) ext_clk = 1'b1;
        end
    endtask

    // Presents the next bit, least significant first, on each fall.
    always @(negedge line) begin
        if (n < 8) begin
            sdi = rx_byte[n];
        end
        if (!fell) begin
            t_fall = $time;
        end
        fell = 1'b1;
    end

    // Captures the port's bit on each rise; after the byte the line toggles so no stale level lingers.
    always @(posedge line) begin
        if (n < 8) begin
            cap = {sdo, cap[7:1]};
            period = $time - t_rise;
            t_rise = $time;
            n++;
        end else begin
            sdi = ~sdi;
        end
    end
endmodule // ssp_peer

`default_nettype wire

// >>> sim/ssp_top_tb.sv
// Self-checking bench for the synchronous serial port with its rate timer.
// Assumes the serial peer model and the package are compiled first.
`timescale 1ns/1ns
`default_nettype none

module ssp_top_tb;
    localparam logic [15:0] CTL = ssp_pkg::SERIAL_CONTROL_ADDR;
    localparam logic [15:0] ST = ssp_pkg::SERIAL_STATUS_ADDR;
    localparam logic [15:0] DAT = ssp_pkg::SERIAL_SHIFT_DATA_ADDR;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic sdo, sdo_oe_n, sdi, ck_o, ck_oe_n, ext_clk, line;
    logic tx_pin, rx_pin, ck_pin, xfer_irq, tick_irq;
    logic [15:0] seed = 16'hd834;
    logic [7:0] v, r;
    int n_errors = 0;
    int comparisons = 0;

    // The clock pin carries the port's drive when enabled, else the peer's.
    assign line = ck_oe_n ? ext_clk : ck_o;

    always #20 clk = ~clk;

    ssp_top i_dut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .WDATA(wdata), .RDATA(rdata), .SERIAL_OUT(sdo), .SERIAL_OUT_OE_N(sdo_oe_n),
        .SERIAL_IN(sdi), .SERIAL_CLK_I(line), .SERIAL_CLK_O(ck_o), .SERIAL_CLK_OE_N(ck_oe_n),
        .TX_PIN_SERIAL(tx_pin), .RX_PIN_SERIAL(rx_pin), .CLK_PIN_SERIAL(ck_pin),
        .XFER_IRQ(xfer_irq), .TICK_IRQ(tick_irq));

    ssp_peer i_peer (.line(line), .sdo(sdo), .sdi(sdi), .ext_clk(ext_clk));

    // Next value of the random source, a sixteen-bit shift register with feedback.
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected clock period in ns and first fall in cycles for a rate.
    function automatic longint exp_period(input int rate);
        return (24 << rate) * 40;
    endfunction
    function automatic int exp_first(input int rate);
        return 12 << rate;
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // Register write and read, one strobe cycle each.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_stb = 1'b1;
        @(negedge clk);
        wr_stb = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd_stb = 1'b1;
        @(negedge clk);
        rd_stb = 1'b0;
        d = rdata;
    endtask

    // Waits, bounded, for the done or the tick request.
    task automatic wait_irq(input bit tick);
        int k;
        k = 0;
        while ((tick ? tick_irq : xfer_irq) !== 1'b1 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        if (k == 5000) begin
            $display("wrong value irq expected 1 seen 0");
            n_errors++;
            final_report();
        end
    endtask

    // One byte each way; half is zero for the internal clock, else the peer's half period in ns.
    task automatic frame(input logic [7:0] ctl, input int half);
        logic [7:0] tx, rx;
        time t0;
        int d;
        tx = seed[7:0];
        rx = seed[15:8];
        seed = lfsr_next(seed);
        wr(CTL, ctl);
        wr(DAT, tx);
        t0 = $time - 20;
        i_peer.arm(rx);
        if (half != 0) begin
            i_peer.ext_frame(half);
        end
        wait_irq(1'b0);
        check("bits at done", 8'h08, 8'(i_peer.n));
        check("tx byte", tx, i_peer.cap);
        repeat (4) @(negedge clk);
        check("held msb", {7'h0, tx[7]}, {7'h0, sdo});
        if (half == 0) begin
            d = int'((i_peer.t_fall - t0) / 40);
            check("first fall", 8'h01, {7'h0, d >= exp_first(ctl[3:0]) && d <= exp_first(ctl[3:0]) + 3});
            check("period", 8'h01, {7'h0, i_peer.period == exp_period(ctl[3:0])});
        end else begin
            wr(ST, 8'hb0);
            check("done masked", 8'h00, {7'h0, xfer_irq});
            rd(ST, r);
            check("done kept", 8'h80, r & 8'h80);
            wr(ST, 8'h10);
            check("done cleared", 8'h00, {7'h0, xfer_irq});
        end
        rd(DAT, r);
        check("rx byte", ctl[6] ? rx : 8'h00, r);
        rd(ST, r);
        check("done after read", 8'h00, r & 8'h80);
        $display("test frame %h done", ctl);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        rd(ST, v);
        check("status reset", 8'h30, v);
        rd(CTL, v);
        check("control reset", 8'h00, v);
        rd(16'h0013, v);
        check("unmapped", 8'h00, v);
        check("pins reset", 8'h03, {3'h0, tx_pin, rx_pin, ck_pin, sdo_oe_n, ck_oe_n});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = {seed[7:6], 2'(i), seed[3:0]};
            seed = lfsr_next(seed);
            wr(CTL, v);
            rd(CTL, r);
            check("control", v, r);
            check("pins", {3'h0, v[7:5], ~v[7], v[5:4] != 2'h2}, {3'h0, tx_pin, rx_pin, ck_pin, sdo_oe_n, ck_oe_n});
        end
        $display("test control done");
        wr(ST, 8'h10);
        frame(8'ha0, 0);
        frame({6'h38, 1'b1, seed[0]}, 0);
        frame({4'hf, seed[3:0]}, 330);
        wr(CTL, 8'h20);
        wr(ST, 8'h30);
        repeat (40) @(negedge clk);
        rd(ST, v);
        check("tick masked", 8'h70, v);
        check("tick irq masked", 8'h00, {7'h0, tick_irq});
        wr(ST, 8'h28);
        rd(ST, v);
        check("tick cleared", 8'h20, v);
        wait_irq(1'b1);
        wr(CTL, 8'h30);
        wr(ST, 8'h20);
        wait_irq(1'b1);
        $display("test timer done");
        final_report();
    end
endmodule // ssp_top_tb

`default_nettype wire
